// *** rtl/osr_consts.vh ***
// Behaviour
// - Refuse OTP program when target lock set
// - OTP read uses single-line command/address/data
// - Opcode is eight clocks, MSB first
// - OTP read takes 24 address clocks
// - OTP address uses only bits 8 to 0
// - One dummy byte before OTP data
// - OTP data MSB first, byte per eight
// - OTP read streams through all four registers
// - 05h/35h/15h read status bytes 1-3
// - Direct status read has no address phase
// - Direct status read repeats same byte
// - Each repeat shows the live value
// - Deselect ends read, releases output line
// - 65h with index selects status byte
// - Indexed status read is single-line
// - Indexed read takes one address byte
// - One dummy byte before indexed data
// - Index advances after every byte
// - Index 0 and 7-255 undefined, wraps FFh to 00h
// - OTP bits 6:0 byte, 8:7 register
// - Lock flags are status byte 2 bits 5:3
`ifndef OSR_CONSTS_VH
`define OSR_CONSTS_VH

// ==========================================================
// Opcodes
`define OSR_OP_OTP_READ 8'h4b
`define OSR_OP_STAT1 8'h05
`define OSR_OP_STAT2 8'h35
`define OSR_OP_STAT3 8'h15
`define OSR_OP_STAT_IDX 8'h65

// ==========================================================
// Status byte indices
`define OSR_STATUS_BYTE_1 8'h01
`define OSR_STATUS_BYTE_2 8'h02
`define OSR_STATUS_BYTE_3 8'h03
`define OSR_STATUS_BYTE_6 8'h06
`define OSR_UNDEF_DATA 8'h00

// ==========================================================
// Field positions and frame lengths
`define OSR_LOCK_LSB 11
`define OSR_LOCK_MSB 13
`define OSR_OTP_AW 9
`define OSR_OTP_BYTES 512
`define OSR_OTP_ADDR_BITS 5'd24
`define OSR_IDX_ADDR_BITS 5'd8
`define OSR_BYTE_BITS 5'd8
`define OSR_FIFO_DEPTH 16
`define OSR_FIFO_AW 4

`endif

// *** rtl/osr_cmd.v ***
`timescale 1ns/1ps
`include "osr_consts.vh"

// ==========================================================
// Program word buffer
module osr_fifo #(
    parameter W = 17,
    parameter D = `OSR_FIFO_DEPTH,
    parameter AW = `OSR_FIFO_AW
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Fill side
    input wire in_valid,
    output reg in_ready,
    input wire [W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    reg [AW:0] cnt_d;
    wire push;
    wire pop;

    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Occupancy after this cycle
    always @* begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Storage has no reset; pointers, count and ready do
    always @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    // Pointers, count and registered ready
    always @(posedge clk) begin
        if (rst) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            // Ready from next count, so full is never overrun
            in_ready <= (cnt_d < D);
            if (push) begin
                wp_q <= (wp_q == D - 1) ? {AW{1'b0}} : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == D - 1) ? {AW{1'b0}} : rp_q + 1'b1;
            end
        end
    end
endmodule // osr_fifo

// ==========================================================
// Serial command front end for OTP and status reads
module osr_cmd #(
    parameter FIFO_DEPTH = `OSR_FIFO_DEPTH,
    parameter FIFO_AW = `OSR_FIFO_AW
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Serial pins
    input wire cs_n,
    input wire sck,
    input wire si,
    output reg so,
    output reg so_oe,
    // Live status bytes 1 to 6, byte n in [8n-1:8n-8]
    input wire [47:0] status_bytes,
    // OTP program words from the device core
    input wire otp_wr_valid,
    output wire otp_wr_ready,
    input wire [8:0] otp_wr_addr,
    input wire [7:0] otp_wr_data,
    // Program outcome pulses
    output reg otp_wr_done,
    output reg otp_wr_abort,
    // Serial read in progress
    output reg read_busy
);
    // ======================================================
    // States
    localparam [4:0] ST_CMD = 5'b00001;
    localparam [4:0] ST_ADDR = 5'b00010;
    localparam [4:0] ST_DUMMY = 5'b00100;
    localparam [4:0] ST_DATA = 5'b01000;
    localparam [4:0] ST_IGNORE = 5'b10000;

    // Data source of the current read
    localparam [1:0] SRC_OTP = 2'd0;
    localparam [1:0] SRC_DIRECT = 2'd1;
    localparam [1:0] SRC_INDEX = 2'd2;

    reg [7:0] otp_mem [0:`OSR_OTP_BYTES-1];

    reg cs_s1_q, cs_s2_q;
    reg sck_s1_q, sck_s2_q, sck_prev_q;
    reg si_s1_q, si_s2_q;
    reg [4:0] st_q;
    reg [4:0] cnt_q;
    reg [4:0] need_q;
    reg [23:0] sh_q;
    reg [1:0] src_q;
    reg [8:0] otp_ptr_q;
    reg [7:0] idx_q;
    reg [2:0] bit_q;
    reg [7:0] cur_byte;
    reg [23:0] sh_next;
    reg [7:0] opcode;
    wire sel;
    wire rise;
    wire fall;
    wire [2:0] otp_lock_flags;
    wire [16:0] fifo_dout;
    wire fifo_valid;
    wire drain_ready;
    wire [1:0] wr_reg;
    wire wr_locked;

    // ======================================================
    // Pin synchronisers; the second stage is used, plus a third for sck edges
    always @(posedge clk) begin
        if (rst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_prev_q <= 1'b0;
            si_s1_q <= 1'b0;
            si_s2_q <= 1'b0;
        end else begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            sck_s1_q <= sck;
            sck_s2_q <= sck_s1_q;
            sck_prev_q <= sck_s2_q;
            si_s1_q <= si;
            si_s2_q <= si_s1_q;
        end
    end

    // Sample on rising edge, drive on falling edge
    assign sel = !cs_s2_q;
    assign rise = sel && sck_s2_q && !sck_prev_q;
    assign fall = sel && !sck_s2_q && sck_prev_q;

    // ======================================================
    // Outgoing byte
    // Status bytes are looked up per bit, so repeats are live
    always @* begin
        cur_byte = `OSR_UNDEF_DATA;
        case (src_q)
            SRC_OTP: begin
                cur_byte = otp_mem[otp_ptr_q];
            end
            SRC_DIRECT, SRC_INDEX: begin
                if (idx_q >= `OSR_STATUS_BYTE_1 &&
                    idx_q <= `OSR_STATUS_BYTE_6) begin
                    cur_byte = status_bytes[idx_q*8-1 -: 8];
                end
            end
            default: begin
                cur_byte = `OSR_UNDEF_DATA;
            end
        endcase
    end

    // Shift register with the newly sampled bit
    always @* begin
        sh_next = {sh_q[22:0], si_s2_q};
        opcode = sh_next[7:0];
    end

    // ======================================================
    // Command sequencer
    always @(posedge clk) begin
        if (rst) begin
            st_q <= ST_CMD;
            cnt_q <= 5'd0;
            need_q <= 5'd0;
            sh_q <= 24'h000000;
            src_q <= SRC_OTP;
            otp_ptr_q <= 9'h000;
            idx_q <= 8'h00;
            bit_q <= 3'd7;
            so <= 1'b0;
            so_oe <= 1'b0;
            read_busy <= 1'b0;
        end else if (!sel) begin
            // Deselect ends any frame at any bit
            st_q <= ST_CMD;
            cnt_q <= 5'd0;
            sh_q <= 24'h000000;
            bit_q <= 3'd7;
            so <= 1'b0;
            so_oe <= 1'b0;
            read_busy <= 1'b0;
        end else begin
            case (st_q)
                ST_CMD: begin
                    if (rise) begin
                        sh_q <= sh_next;
                        cnt_q <= cnt_q + 1'b1;
                        if (cnt_q == `OSR_BYTE_BITS - 1'b1) begin
                            cnt_q <= 5'd0;
                            bit_q <= 3'd7;
                            read_busy <= 1'b1;
                            case (opcode)
                                `OSR_OP_OTP_READ: begin
                                    src_q <= SRC_OTP;
                                    need_q <= `OSR_OTP_ADDR_BITS;
                                    st_q <= ST_ADDR;
                                end
                                `OSR_OP_STAT_IDX: begin
                                    src_q <= SRC_INDEX;
                                    need_q <= `OSR_IDX_ADDR_BITS;
                                    st_q <= ST_ADDR;
                                end
                                `OSR_OP_STAT1: begin
                                    src_q <= SRC_DIRECT;
                                    idx_q <= `OSR_STATUS_BYTE_1;
                                    st_q <= ST_DATA;
                                end
                                `OSR_OP_STAT2: begin
                                    src_q <= SRC_DIRECT;
                                    idx_q <= `OSR_STATUS_BYTE_2;
                                    st_q <= ST_DATA;
                                end
                                `OSR_OP_STAT3: begin
                                    src_q <= SRC_DIRECT;
                                    idx_q <= `OSR_STATUS_BYTE_3;
                                    st_q <= ST_DATA;
                                end
                                default: begin
                                    // Other commands belong elsewhere
                                    read_busy <= 1'b0;
                                    st_q <= ST_IGNORE;
                                end
                            endcase
                        end
                    end
                end
                ST_ADDR: begin
                    if (rise) begin
                        sh_q <= sh_next;
                        cnt_q <= cnt_q + 1'b1;
                        if (cnt_q == need_q - 1'b1) begin
                            cnt_q <= 5'd0;
                            otp_ptr_q <= sh_next[8:0];
                            idx_q <= sh_next[7:0];
                            st_q <= ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    // Dummy bits are counted, not stored
                    if (rise) begin
                        cnt_q <= cnt_q + 1'b1;
                        if (cnt_q == `OSR_BYTE_BITS - 1'b1) begin
                            cnt_q <= 5'd0;
                            st_q <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    // Input line is not looked at here
                    if (fall) begin
                        so <= cur_byte[bit_q];
                        so_oe <= 1'b1;
                        bit_q <= bit_q - 1'b1;
                        if (bit_q == 3'd0) begin
                            // Pointer wraps 511 to 0 across registers
                            if (src_q == SRC_OTP) begin
                                otp_ptr_q <= otp_ptr_q + 1'b1;
                            end
                            // Index wraps FFh to 00h
                            if (src_q == SRC_INDEX) begin
                                idx_q <= idx_q + 1'b1;
                            end
                            // Direct reads keep the same byte
                            bit_q <= 3'd7;
                        end
                    end
                end
                ST_IGNORE: begin
                    // Wait for deselect
                    so_oe <= 1'b0;
                end
                default: begin
                    st_q <= ST_CMD;
                end
            endcase
        end
    end

    // ======================================================
    // Program path: words buffered, checked against lock flags
    osr_fifo #(
        .W(17),
        .D(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(otp_wr_valid),
        .in_ready(otp_wr_ready),
        .in_data({otp_wr_addr, otp_wr_data}),
        .out_valid(fifo_valid),
        .out_ready(drain_ready),
        .out_data(fifo_dout)
    );

    // Writes stall during a serial read so a streamed byte
    // never changes under the shifter; the buffer fills instead
    assign drain_ready = !read_busy;

    assign otp_lock_flags =
        status_bytes[`OSR_LOCK_MSB:`OSR_LOCK_LSB];
    assign wr_reg = fifo_dout[16:15];

    // Register 0 is factory content and always refused
    assign wr_locked = (wr_reg == 2'd0) ? 1'b1 :
        otp_lock_flags[wr_reg - 2'd1];

    // Array write or abort
    always @(posedge clk) begin
        if (fifo_valid && drain_ready && !wr_locked) begin
            otp_mem[fifo_dout[16:8]] <= fifo_dout[7:0];
        end
    end

    // Outcome pulses
    always @(posedge clk) begin
        if (rst) begin
            otp_wr_done <= 1'b0;
            otp_wr_abort <= 1'b0;
        end else begin
            otp_wr_done <= fifo_valid && drain_ready && !wr_locked;
            otp_wr_abort <= fifo_valid && drain_ready && wr_locked;
        end
    end
endmodule // osr_cmd

// *** bench/osr_cmd_assertions.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port checks, serial reads and program port
module osr_cmd_chk #(
    parameter FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Serial pins
    input wire cs_n,
    input wire sck,
    input wire so,
    input wire so_oe,
    // Program port and read state
    input wire otp_wr_valid,
    input wire otp_wr_ready,
    input wire otp_wr_done,
    input wire otp_wr_abort,
    input wire read_busy
);
    reg [5:0] pend_q;
    wire [5:0] pend_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Words taken but not yet answered
    assign pend_d = pend_q + {5'h00, otp_wr_valid & otp_wr_ready}
        - {5'h00, otp_wr_done | otp_wr_abort};
    // Outstanding word count, so a result can be tied to its word
    always @(posedge clk) begin
        if (rst)
            pend_q <= 6'h00;
        else
            pend_q <= pend_d;
    end
    a_result_has_word: assert property (
        (otp_wr_done | otp_wr_abort) |->
        pend_q != 6'h00 && pend_q <= FIFO_DEPTH + 2)
        else $error("program result without a pending word");
    a_result_one_kind: assert property (
        !(otp_wr_done && otp_wr_abort))
        else $error("done and abort in the same cycle");
    a_oe_released: assert property (
        cs_n [*6] |-> !so_oe)
        else $error("output still driven after deselect");
    a_busy_released: assert property (
        cs_n [*6] |-> !read_busy)
        else $error("read still busy after deselect");
    a_so_steady: assert property (
        sck [*5] |-> $stable(so))
        else $error("output bit moved while clock high");
    a_oe_start: assert property (
        $rose(so_oe) |-> !cs_n && !sck && read_busy)
        else $error("output enabled outside a decoded read");
    a_busy_start: assert property (
        $rose(read_busy) |-> !cs_n)
        else $error("read started while deselected");
    a_oe_holds: assert property (
        so_oe && !cs_n |=> so_oe)
        else $error("output dropped while still selected");
endmodule // osr_cmd_chk

bind osr_cmd osr_cmd_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .so(so), .so_oe(so_oe),
    .otp_wr_valid(otp_wr_valid), .otp_wr_ready(otp_wr_ready),
    .otp_wr_done(otp_wr_done), .otp_wr_abort(otp_wr_abort),
    .read_busy(read_busy)
);

// *** bench/osr_host.sv ***
`timescale 1ns/1ps
// ==========================================================
// Host serial controller, mode 0, 160 ns bit time
module osr_host (
    // Clock
    input logic clk,
    // Serial pins
    output logic cs_n,
    output logic sck,
    output logic si,
    input logic so
);
    // Deselected, clock parked low outside frames
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // Select, then let the synchronisers see it
    task automatic start;
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // Shift n bits MSB first; so is read at the rising edge
    task automatic xfer(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sck = 1'b0;
            si = tx[i];
            repeat (8) @(negedge clk);
            sck = 1'b1;
            rx[i] = so;
            repeat (8) @(negedge clk);
        end
    endtask
    // Deselect with clock low; si flips so no stale bit lingers
    task automatic stop;
        sck = 1'b0;
        repeat (8) @(negedge clk);
        cs_n = 1'b1;
        si = ~si;
        repeat (10) @(negedge clk);
    endtask
endmodule // osr_host

// *** bench/test_osr_cmd.sv ***
`timescale 1ns/1ps
`include "osr_consts.vh"
// ==========================================================
// Bench for OTP and status read commands
module test_osr_cmd;
    logic clk, rst, cs_n, sck, si, so, so_oe, read_busy;
    logic otp_wr_valid, otp_wr_ready, otp_wr_done, otp_wr_abort;
    logic [47:0] status_bytes;
    logic [8:0] otp_wr_addr;
    logic [7:0] otp_wr_data, rx;
    logic [7:0] ops [3] = '{`OSR_OP_STAT1, `OSR_OP_STAT2, `OSR_OP_STAT3};
    int fails, n_checks;
    wire so_line;
    // Pull-up on the output line, so a released pin reads high
    assign so_line = so_oe ? so : 1'b1;
    osr_cmd dut (
        .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
        .so_oe(so_oe), .status_bytes(status_bytes),
        .otp_wr_valid(otp_wr_valid), .otp_wr_ready(otp_wr_ready),
        .otp_wr_addr(otp_wr_addr), .otp_wr_data(otp_wr_data),
        .otp_wr_done(otp_wr_done), .otp_wr_abort(otp_wr_abort),
        .read_busy(read_busy)
    );
    osr_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Counts, verdict, end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One whole byte each way
    task automatic b(input logic [7:0] tx);
        host.xfer(tx, 8, rx);
    endtask
    // Offer a word, hold it until taken, expect done or abort
    task automatic prog(input logic [8:0] a, input logic [7:0] d,
                        input logic ab);
        int k;
        otp_wr_valid = 1'b1;
        otp_wr_addr = a;
        otp_wr_data = d;
        // Ready seen at a falling edge is what the next rise takes
        while (otp_wr_ready !== 1'b1)
            @(negedge clk);
        @(negedge clk);
        otp_wr_valid = 1'b0;
        for (k = 0; k < 40 && !(otp_wr_done | otp_wr_abort); k++)
            @(negedge clk);
        check({6'h00, otp_wr_done, otp_wr_abort}, {6'h00, !ab, ab});
    endtask
    // Test sequence
    initial begin
        rst = 1'b1;
        status_bytes = 48'h00;
        otp_wr_valid = 1'b0;
        otp_wr_addr = 9'h000;
        otp_wr_data = 8'h00;
        fails = 0;
        n_checks = 0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        // Unlocked words land; register 0 and locked ones refused
        prog(9'h17f, 8'ha5, 1'b0);
        prog(9'h180, 8'h3c, 1'b0);
        prog(9'h005, 8'h11, 1'b1);
        for (int r = 1; r < 4; r++) begin
            status_bytes[10 + r] = 1'b1;
            prog({r[1:0], 7'h00}, 8'h00, 1'b1);
        end
        // OTP read: top address bits ignored, runs across registers
        host.start();
        b(`OSR_OP_OTP_READ);
        b(8'hff);
        b(8'hff);
        b(8'h7f);
        b(8'h5a);
        b(`OSR_OP_STAT1);
        check(rx, 8'ha5);
        b(8'h00);
        check(rx, 8'h3c);
        host.stop();
        // Direct reads repeat the byte with its live value
        for (int n = 1; n < 4; n++) begin
            status_bytes[8 * n - 8 +: 8] = 8'h40 | n[7:0];
            host.start();
            b(ops[n - 1]);
            b(`OSR_OP_STAT_IDX);
            check(rx, 8'h40 | n[7:0]);
            status_bytes[8 * n - 8 +: 8] = 8'h90 | n[7:0];
            b(8'h00);
            check(rx, 8'h90 | n[7:0]);
            host.stop();
        end
        // Deselect three bits into a byte
        host.start();
        b(`OSR_OP_STAT1);
        host.xfer(8'h00, 3, rx);
        check(rx & 8'he0, 8'h80);
        host.stop();
        check({6'h00, so_oe, read_busy}, 8'h00);
        // Indexed read from 01h past 06h, then wrap from FFh
        status_bytes = 48'h363534333231;
        host.start();
        b(`OSR_OP_STAT_IDX);
        b(`OSR_STATUS_BYTE_1);
        b(8'h65);
        for (int n = 1; n < 8; n++) begin
            b(8'h00);
            check(rx, n < 7 ? 8'h30 | n[7:0] : `OSR_UNDEF_DATA);
        end
        host.stop();
        host.start();
        b(`OSR_OP_STAT_IDX);
        b(8'hff);
        repeat (4) b(8'h00);
        check(rx, 8'h31);
        host.stop();
        // Unknown opcode leaves the output line released
        host.start();
        b(8'h9f);
        b(8'h00);
        check(rx, 8'hff);
        check({7'h00, so_oe}, 8'h00);
        host.stop();
        conclude();
    end
    // Watchdog: the sequence needs about 4700 cycles
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        $display("wrong value at %0t: timeout", $time);
        conclude();
    end
endmodule // test_osr_cmd
